// ### rtl/apcsd_pkg.sv
// Purpose: Shared constants and types for the auxiliary port chip-select decoder.
// Assumes: 8-bit special function register bus, 16-bit external data address.
// Notes:   Every offset and field position is named once here; reset values too, except the synchroniser and pin stage ones.
package apcsd_pkg;

  // Pin count and widths
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned AW       = 16;
  localparam int unsigned DW       = 8;

  // Register offsets on the special function register bus
  localparam logic [7:0] OFS_POLARITY  = 8'hae;
  localparam logic [7:0] OFS_CTRL_LO   = 8'hc2;
  localparam logic [7:0] OFS_CTRL_HI   = 8'hc3;
  localparam logic [7:0] OFS_PORT_DATA = 8'hd8;
  localparam logic [7:0] OFS_BASE_LO [NUM_PINS] = '{8'h84, 8'h94, 8'hac, 8'hb4};
  localparam logic [7:0] OFS_BASE_HI [NUM_PINS] = '{8'h85, 8'h95, 8'had, 8'hb5};

  // Field layout: each control register holds two 4-bit pin nibbles
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned FUN_LSB  = 2;
  localparam int unsigned LEN_LSB  = 0;
  localparam int unsigned POL_LSB  = 4;
  localparam int unsigned RSV_LSB  = 2;

  // Reset values
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam logic [7:0] RST_POLARITY  = 8'h00;
  localparam logic [7:0] RST_BASE      = 8'h00;
  localparam logic [3:0] RST_PORT_DATA = 4'hf;
  localparam logic [7:0] RDATA_NONE    = 8'h00;

  // Address compare masks per comparison length
  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] MASK_A1   = 16'hfffe;
  localparam logic [15:0] MASK_A2   = 16'hfffc;
  localparam logic [15:0] MASK_A8   = 16'hff00;

  // Pin function modes
  typedef enum logic [1:0] {
    FUN_GPIO  = 2'h0,
    FUN_RD    = 2'h1,
    FUN_WR    = 2'h2,
    FUN_RDWR  = 2'h3
  } apcsd_fun_t;

  // Address comparison lengths
  typedef enum logic [1:0] {
    LEN_FULL = 2'h0,
    LEN_A1   = 2'h1,
    LEN_A2   = 2'h2,
    LEN_A8   = 2'h3
  } apcsd_len_t;

endpackage : apcsd_pkg

// ### rtl/apcsd_addr_match.sv
// Purpose: Masked comparison of the external data address against one base address.
// Assumes: Address and base are on the core clock; purely combinational.
// Notes:   The length field selects how many low address bits are ignored.
`timescale 1ns/1ps
`default_nettype none
module apcsd_addr_match (
  input  wire logic [15:0]            addr_in,
  input  wire logic [15:0]            base_in,
  input  wire apcsd_pkg::apcsd_len_t  len_in,
  output logic                        match_out
);

  logic [15:0] mask;

  // Mask select and compare
  always_comb begin
    mask = apcsd_pkg::MASK_FULL;
    unique case (len_in)
      apcsd_pkg::LEN_FULL: mask = apcsd_pkg::MASK_FULL;
      apcsd_pkg::LEN_A1:   mask = apcsd_pkg::MASK_A1;
      apcsd_pkg::LEN_A2:   mask = apcsd_pkg::MASK_A2;
      apcsd_pkg::LEN_A8:   mask = apcsd_pkg::MASK_A8;
    endcase
    match_out = ((addr_in ^ base_in) & mask) == 16'h0000;
  end

endmodule : apcsd_addr_match
`default_nettype wire

// ### rtl/apcsd_pin_drive.sv
// Purpose: Output stage of one auxiliary pin: port bit or chip-select strobe.
// Assumes: Core read, write and fetch strobes are active high, same clock.
// Notes:   Pin level and enable are registered, so they lag the strobe by one cycle.
`timescale 1ns/1ps
`default_nettype none
module apcsd_pin_drive (
  input  wire logic                   clk_sys_in,
  input  wire logic                   resetn_in,
  input  wire apcsd_pkg::apcsd_fun_t  fun_in,
  input  wire logic                   pol_in,
  input  wire logic                   match_in,
  input  wire logic                   xbus_rd_in,
  input  wire logic                   xbus_wr_in,
  input  wire logic                   xbus_fetch_in,
  input  wire logic                   port_bit_in,
  output logic                        pin_out,
  output logic                        pin_oe_out
);

  logic active;
  logic pin_d;
  logic pin_q;
  logic oe_d;
  logic oe_q;

  // Strobe decode and pin next state
  always_comb begin
    active = 1'b0;
    unique case (fun_in)
      apcsd_pkg::FUN_GPIO: active = 1'b0;
      apcsd_pkg::FUN_RD:   active = xbus_rd_in;
      apcsd_pkg::FUN_WR:   active = xbus_wr_in;
      apcsd_pkg::FUN_RDWR: active = xbus_rd_in | xbus_wr_in;
    endcase
    active = active & match_in & ~xbus_fetch_in;
    if (fun_in == apcsd_pkg::FUN_GPIO) begin
      pin_d = port_bit_in;
      oe_d  = ~port_bit_in;                                    // Quasi: only a 0 is driven
    end else begin
      pin_d = pol_in ? active : ~active;
      oe_d  = 1'b1;
    end
  end

  // Pin registers; released high out of reset
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pin_q <= 1'b1;
      oe_q  <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_out    = pin_q;
  assign pin_oe_out = oe_q;

endmodule : apcsd_pin_drive
`default_nettype wire

// ### rtl/apcsd_top.sv
// Purpose: Register file and per-pin decode of the auxiliary chip-select port.
// Assumes: Core drives the register bus and external bus strobes on clk_sys_in.
// Notes:   Pins are quasi-bidirectional in port mode; inputs are double synchronised.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Function 00 makes the pin a quasi-bidirectional port bit.
// - Function 01 makes the pin a read chip-select on address match.
// - Function 10 makes the pin a write chip-select on address match.
// - Function 11 asserts the pin on matching reads and writes.
// - Length 00 compares all sixteen address bits.
// - Length 01 ignores address bit 0.
// - Length 10 ignores address bits 1 and 0.
// - Length 11 ignores the low address byte.
// - High control register holds pin 3 and pin 2 fields.
// - Low control register holds pin 1 and pin 0 fields.
// - Polarity bit 7 set makes pin 3 strobe active high.
// - Polarity bits 6, 5, 4 set pins 2, 1, 0 likewise.
// - Chip-select outputs follow the core read or write strobe except during a program fetch.
// - Each pin has a sixteen bit base address in two bytes.
// - Port mode drives the matching low bit of the port data register.
// - Reset clears control, polarity and base registers; pins start as port.
module apcsd_top (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  output logic      [7:0]  sfr_rdata_out,
  input  wire logic [15:0] xbus_addr_in,
  input  wire logic        xbus_rd_in,
  input  wire logic        xbus_wr_in,
  input  wire logic        xbus_fetch_in,
  input  wire logic [3:0]  aux_pin_in,
  output logic      [3:0]  aux_pin_out,
  output logic      [3:0]  aux_pin_oe_out
);

  localparam int unsigned NP = apcsd_pkg::NUM_PINS;

  logic [7:0]  ctrl_lo_d;
  logic [7:0]  ctrl_lo_q;
  logic [7:0]  ctrl_hi_d;
  logic [7:0]  ctrl_hi_q;
  logic [7:0]  pol_d;
  logic [7:0]  pol_q;
  logic [3:0]  port_d;
  logic [3:0]  port_q;
  logic [15:0] base_d [NP];
  logic [15:0] base_q [NP];
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [15:0] ctrl_w;

  apcsd_pkg::apcsd_fun_t fun_w [NP];
  apcsd_pkg::apcsd_len_t len_w [NP];
  logic [NP-1:0]         pol_w;
  logic [NP-1:0]         match_w;

  // Register writes from the special function register bus
  // Reserved polarity bits 3:2 are stored but feed nothing; bits 1:0 stay zero
  always_comb begin
    ctrl_lo_d = ctrl_lo_q;
    ctrl_hi_d = ctrl_hi_q;
    pol_d     = pol_q;
    port_d    = port_q;
    base_d    = base_q;
    if (sfr_wr_in) begin
      unique case (sfr_addr_in)
        apcsd_pkg::OFS_CTRL_LO:   ctrl_lo_d = sfr_wdata_in;
        apcsd_pkg::OFS_CTRL_HI:   ctrl_hi_d = sfr_wdata_in;
        apcsd_pkg::OFS_POLARITY:  pol_d = {sfr_wdata_in[7:2], 2'b00};
        apcsd_pkg::OFS_PORT_DATA: port_d = sfr_wdata_in[3:0];
        default: ;
      endcase
      for (int i = 0; i < NP; i++) begin
        if (sfr_addr_in == apcsd_pkg::OFS_BASE_LO[i]) begin
          base_d[i][7:0] = sfr_wdata_in;
        end
        if (sfr_addr_in == apcsd_pkg::OFS_BASE_HI[i]) begin
          base_d[i][15:8] = sfr_wdata_in;
        end
      end
    end
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = apcsd_pkg::RDATA_NONE;
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        apcsd_pkg::OFS_CTRL_LO:   rdata_d = ctrl_lo_q;
        apcsd_pkg::OFS_CTRL_HI:   rdata_d = ctrl_hi_q;
        apcsd_pkg::OFS_POLARITY:  rdata_d = pol_q;
        apcsd_pkg::OFS_PORT_DATA: rdata_d = {4'h0, sync2_q};    // Pin levels
        default: ;
      endcase
      for (int i = 0; i < NP; i++) begin
        if (sfr_addr_in == apcsd_pkg::OFS_BASE_LO[i]) begin
          rdata_d = base_q[i][7:0];
        end
        if (sfr_addr_in == apcsd_pkg::OFS_BASE_HI[i]) begin
          rdata_d = base_q[i][15:8];
        end
      end
    end
  end

  // Register state and pin input synchroniser
  // Pads are asynchronous to the core clock; only the second stage is read
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ctrl_lo_q <= apcsd_pkg::RST_CTRL;
      ctrl_hi_q <= apcsd_pkg::RST_CTRL;
      pol_q     <= apcsd_pkg::RST_POLARITY;
      port_q    <= apcsd_pkg::RST_PORT_DATA;
      for (int i = 0; i < NP; i++) begin
        base_q[i] <= {apcsd_pkg::RST_BASE, apcsd_pkg::RST_BASE};
      end
      rdata_q   <= apcsd_pkg::RDATA_NONE;
      sync1_q   <= 4'hf;
      sync2_q   <= 4'hf;
    end else begin
      ctrl_lo_q <= ctrl_lo_d;
      ctrl_hi_q <= ctrl_hi_d;
      pol_q     <= pol_d;
      port_q    <= port_d;
      base_q    <= base_d;
      rdata_q   <= rdata_d;
      sync1_q   <= aux_pin_in;
      sync2_q   <= sync1_q;
    end
  end

  assign sfr_rdata_out = rdata_q;
  // Pin i owns nibble i of the two control bytes taken as one vector
  assign ctrl_w        = {ctrl_hi_q, ctrl_lo_q};

  // Per-pin field extraction, comparator and output stage
  for (genvar i = 0; i < NP; i++) begin : g_pin
    assign fun_w[i] = apcsd_pkg::apcsd_fun_t'(
                        ctrl_w[i*apcsd_pkg::NIB_W + apcsd_pkg::FUN_LSB +: 2]);
    assign len_w[i] = apcsd_pkg::apcsd_len_t'(
                        ctrl_w[i*apcsd_pkg::NIB_W + apcsd_pkg::LEN_LSB +: 2]);
    assign pol_w[i] = pol_q[apcsd_pkg::POL_LSB + i];

    apcsd_addr_match u_match (
      .addr_in   (xbus_addr_in),
      .base_in   (base_q[i]),
      .len_in    (len_w[i]),
      .match_out (match_w[i])
    );

    apcsd_pin_drive u_drive (
      .clk_sys_in    (clk_sys_in),
      .resetn_in     (resetn_in),
      .fun_in        (fun_w[i]),
      .pol_in        (pol_w[i]),
      .match_in      (match_w[i]),
      .xbus_rd_in    (xbus_rd_in),
      .xbus_wr_in    (xbus_wr_in),
      .xbus_fetch_in (xbus_fetch_in),
      .port_bit_in   (port_q[i]),
      .pin_out       (aux_pin_out[i]),
      .pin_oe_out    (aux_pin_oe_out[i])
    );

    // Pin behaviour checks
    a_gpio_level: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      fun_w[i] == apcsd_pkg::FUN_GPIO |=>
        aux_pin_out[i] == $past(port_q[i]) && aux_pin_oe_out[i] == !$past(port_q[i]))
      else $error("port mode pin does not follow its data bit");
    a_read_strobe: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      fun_w[i] == apcsd_pkg::FUN_RD && match_w[i] && !xbus_fetch_in |=>
        aux_pin_out[i] == ($past(xbus_rd_in) ? $past(pol_w[i]) : !$past(pol_w[i])))
      else $error("read strobe pin wrong");
    a_write_strobe: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      fun_w[i] == apcsd_pkg::FUN_WR && match_w[i] && !xbus_fetch_in |=>
        aux_pin_out[i] == ($past(xbus_wr_in) ? $past(pol_w[i]) : !$past(pol_w[i])))
      else $error("write strobe pin wrong");
    a_both_strobe: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      fun_w[i] == apcsd_pkg::FUN_RDWR && match_w[i] && !xbus_fetch_in
        && (xbus_rd_in || xbus_wr_in) |=> aux_pin_out[i] == $past(pol_w[i]))
      else $error("read/write strobe pin not asserted");
    a_rest_level: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      fun_w[i] != apcsd_pkg::FUN_GPIO && (!match_w[i] || !(xbus_rd_in || xbus_wr_in)) |=>
        aux_pin_out[i] == !$past(pol_w[i]) && aux_pin_oe_out[i])
      else $error("idle strobe pin not at inactive level");
    a_fetch_quiet: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      fun_w[i] != apcsd_pkg::FUN_GPIO && xbus_fetch_in |=>
        aux_pin_out[i] == !$past(pol_w[i]))
      else $error("strobe asserted on program fetch");
    a_full_compare: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      len_w[i] == apcsd_pkg::LEN_FULL |-> match_w[i] == (xbus_addr_in == base_q[i]))
      else $error("full compare mismatch");
    a_len_a1: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      len_w[i] == apcsd_pkg::LEN_A1 |->
        match_w[i] == (xbus_addr_in[15:1] == base_q[i][15:1]))
      else $error("compare ignoring bit 0 wrong");
    a_len_a2: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      len_w[i] == apcsd_pkg::LEN_A2 |->
        match_w[i] == (xbus_addr_in[15:2] == base_q[i][15:2]))
      else $error("compare ignoring bits 1:0 wrong");
    a_len_a8: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      len_w[i] == apcsd_pkg::LEN_A8 |->
        match_w[i] == (xbus_addr_in[15:8] == base_q[i][15:8]))
      else $error("compare ignoring low byte wrong");
    a_base_write: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_BASE_HI[i] |=>
        base_q[i][15:8] == $past(sfr_wdata_in))
      else $error("base high byte not written");
    // Base byte, drive enable and reset checks
    a_base_low: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_BASE_LO[i] |=>
        base_q[i][7:0] == $past(sfr_wdata_in))
      else $error("base low byte not written");
    a_base_read: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      sfr_rd_in && sfr_addr_in == apcsd_pkg::OFS_BASE_LO[i] |=>
        sfr_rdata_out == $past(base_q[i][7:0]))
      else $error("base low byte read back wrong");
    a_strobe_drive: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      fun_w[i] != apcsd_pkg::FUN_GPIO |=> aux_pin_oe_out[i])
      else $error("strobe pin not driven");
    a_base_reset: assert property (@(posedge clk_sys_in)
      !resetn_in |=> base_q[i] == {apcsd_pkg::RST_BASE, apcsd_pkg::RST_BASE})
      else $error("base address not cleared by reset");
  end

  // Register layout checks
  a_ctrl_layout: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_CTRL_HI |=>
      fun_w[3] == $past(sfr_wdata_in[7:6]) && len_w[2] == $past(sfr_wdata_in[1:0]))
    else $error("high control fields misplaced");
  a_ctrl_lo_layout: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_CTRL_LO |=>
      fun_w[1] == $past(sfr_wdata_in[7:6]) && len_w[0] == $past(sfr_wdata_in[1:0]))
    else $error("low control fields misplaced");
  a_pol_map: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_POLARITY |=>
      pol_w == $past(sfr_wdata_in[7:4]) && pol_q[1:0] == 2'b00)
    else $error("polarity bits misplaced");
  a_reset_clear: assert property (@(posedge clk_sys_in)
    !resetn_in |=> ctrl_w == 16'h0000 && pol_q == 8'h00 && port_q == 4'hf)
    else $error("reset did not clear control state");
  a_ctrl_hi_rest: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_CTRL_HI |=>
      len_w[3] == $past(sfr_wdata_in[5:4]) && fun_w[2] == $past(sfr_wdata_in[3:2]))
    else $error("high control pin fields misplaced");
  a_ctrl_lo_rest: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_CTRL_LO |=>
      len_w[1] == $past(sfr_wdata_in[5:4]) && fun_w[0] == $past(sfr_wdata_in[3:2]))
    else $error("low control pin fields misplaced");
  a_pol_reserved: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_POLARITY |=>
      pol_q[3:2] == $past(sfr_wdata_in[3:2]))
    else $error("reserved polarity bits not stored");

  // Register read and port data checks
  a_read_ctrl_hi: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_rd_in && sfr_addr_in == apcsd_pkg::OFS_CTRL_HI |=>
      sfr_rdata_out == $past(ctrl_hi_q))
    else $error("high control read back wrong");
  a_read_ctrl_lo: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_rd_in && sfr_addr_in == apcsd_pkg::OFS_CTRL_LO |=>
      sfr_rdata_out == $past(ctrl_lo_q))
    else $error("low control read back wrong");
  a_read_pol: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_rd_in && sfr_addr_in == apcsd_pkg::OFS_POLARITY |=>
      sfr_rdata_out == $past(pol_q))
    else $error("polarity read back wrong");
  a_port_write: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_wr_in && sfr_addr_in == apcsd_pkg::OFS_PORT_DATA |=>
      port_q == $past(sfr_wdata_in[3:0]))
    else $error("port data not written");
  a_port_read: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sfr_rd_in && sfr_addr_in == apcsd_pkg::OFS_PORT_DATA |=>
      sfr_rdata_out == {4'h0, $past(sync2_q)})
    else $error("port read does not return pin levels");
  a_reset_pins: assert property (@(posedge clk_sys_in)
    !resetn_in |=> aux_pin_out == 4'hf && aux_pin_oe_out == 4'h0)
    else $error("pins not released high by reset");

  // Main scenarios
  c_read_cs: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    fun_w[0] == apcsd_pkg::FUN_RD && match_w[0] && xbus_rd_in);
  c_write_cs: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    fun_w[0] == apcsd_pkg::FUN_WR && match_w[0] && xbus_wr_in && pol_w[0]);
  c_rdwr_cs: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    fun_w[3] == apcsd_pkg::FUN_RDWR && match_w[3] && len_w[3] == apcsd_pkg::LEN_A8);
  c_gpio_low: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    fun_w[2] == apcsd_pkg::FUN_GPIO && aux_pin_oe_out[2]);
  c_fetch_block: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
    fun_w[1] != apcsd_pkg::FUN_GPIO && match_w[1] && xbus_fetch_in && xbus_rd_in);

endmodule : apcsd_top
`default_nettype wire

// ### dv/apcsd_periph_model.sv
// Purpose: External side of the four auxiliary pins: pull-ups and selected peripherals.
// Assumes: Every pad has a weak pull-up; peripherals only ever pull a released pin low.
// Notes:   The bench commands which released pins a peripheral holds low.
`timescale 1ns/1ps
`default_nettype none
module apcsd_periph_model (
  input  wire logic [3:0] pin_drv_in,
  input  wire logic [3:0] pin_oe_in,
  input  wire logic [3:0] ext_low_in,
  output logic      [3:0] pin_lvl_out
);
  // Driven pins show the device level, released pins the pull-up unless held low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl_out[i] = pin_oe_in[i] ? pin_drv_in[i] : ~ext_low_in[i];
    end
  end
endmodule : apcsd_periph_model
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: Self-checking bench for the auxiliary port chip-select decoder.
// Assumes: Inputs change on the falling edge; outputs lag the core strobes by one clock.
// Notes:   Every pin, chip-select function (01 to 11) and comparison length is swept with hit and miss addresses.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys_in    = 1'b0;
  logic        resetn_in     = 1'b0;
  logic [7:0]  sfr_addr_in   = 8'h00;
  logic [7:0]  sfr_wdata_in  = 8'h00;
  logic        sfr_wr_in     = 1'b0;
  logic        sfr_rd_in     = 1'b0;
  logic [15:0] xbus_addr_in  = 16'h0000;
  logic        xbus_rd_in    = 1'b0;
  logic        xbus_wr_in    = 1'b0;
  logic        xbus_fetch_in = 1'b0;
  logic [3:0]  ext_low       = 4'h0;
  logic [3:0]  aux_pin_in;
  logic [7:0]  sfr_rdata_out;
  logic [3:0]  aux_pin_out;
  logic [3:0]  aux_pin_oe_out;
  logic [15:0] base;
  logic [7:0]  cfg;
  logic        pol;
  int          mismatches    = 0;
  int          total_checks  = 0;
  // Address offsets that stay inside and just outside each comparison length
  logic [15:0] hit_x [4]     = '{16'h0000, 16'h0001, 16'h0003, 16'h00ff};
  logic [15:0] miss_x [4]    = '{16'h0001, 16'h0002, 16'h0004, 16'h0100};

  // Core clock, 8 ns period
  always #4 clk_sys_in = ~clk_sys_in;

  apcsd_top apcsd_top_i (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out), .xbus_addr_in(xbus_addr_in), .xbus_rd_in(xbus_rd_in),
    .xbus_wr_in(xbus_wr_in), .xbus_fetch_in(xbus_fetch_in), .aux_pin_in(aux_pin_in),
    .aux_pin_out(aux_pin_out), .aux_pin_oe_out(aux_pin_oe_out)
  );

  apcsd_periph_model apcsd_periph_model_i (
    .pin_drv_in(aux_pin_out), .pin_oe_in(aux_pin_oe_out), .ext_low_in(ext_low),
    .pin_lvl_out(aux_pin_in)
  );

  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // Compare a register or pin vector
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  // Compare one pin signal
  task automatic chk1(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  // One register write: strobe held for one clock edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    sfr_addr_in  = a;
    sfr_wdata_in = d;
    sfr_wr_in    = 1'b1;
    @(negedge clk_sys_in);
    sfr_wr_in = 1'b0;
  endtask : sfr_wr

  // One register read: data stands in the cycle after the sampling edge
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(negedge clk_sys_in);
    sfr_addr_in = a;
    sfr_rd_in   = 1'b1;
    @(negedge clk_sys_in);
    chk8(name, exp, sfr_rdata_out);
    sfr_rd_in = 1'b0;
  endtask : sfr_rd

  // One external bus cycle on pin p, then the idle cycle after it
  task automatic xacc(input logic [15:0] a, input logic r, input logic w, input logic f,
                      input int p, input logic act, input logic pl);
    @(negedge clk_sys_in);
    xbus_addr_in  = a;
    xbus_rd_in    = r;
    xbus_wr_in    = w;
    xbus_fetch_in = f;
    @(negedge clk_sys_in);
    chk1("strobe level", act ? pl : ~pl, aux_pin_out[p]);
    chk1("strobe enable", 1'b1, aux_pin_oe_out[p]);
    xbus_rd_in    = 1'b0;
    xbus_wr_in    = 1'b0;
    xbus_fetch_in = 1'b0;
    @(negedge clk_sys_in);
    chk1("strobe idle", ~pl, aux_pin_out[p]);
  endtask : xacc

  // Reset for 8 cycles, checking the pins while it is held
  task automatic do_reset;
    resetn_in = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    chk8("pins in reset", 8'h0f, {4'h0, aux_pin_out});
    chk8("enables in reset", 8'h00, {4'h0, aux_pin_oe_out});
    resetn_in = 1'b1;
  endtask : do_reset

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches++;
    $display("[FAIL] run length expected done seen timeout");
    final_report();
  end

  // Main sequence
  initial begin
    do_reset();
    sfr_wr(8'h7f, 8'h5a);
    sfr_rd(8'h7f, 8'h00, "unmapped read");
    // Sweep pin, function mode and comparison length
    for (int p = 0; p < 4; p++) begin
      for (int f = 1; f < 4; f++) begin
        for (int l = 0; l < 4; l++) begin
          base = 16'h4034 + 16'(p << 8);
          pol  = l[0];
          cfg  = {4'h0, f[1:0], l[1:0]} << (4 * (p % 2));
          sfr_wr(apcsd_pkg::OFS_BASE_HI[p], base[15:8]);
          sfr_wr(apcsd_pkg::OFS_BASE_LO[p], base[7:0]);
          sfr_wr((p < 2) ? apcsd_pkg::OFS_CTRL_LO : apcsd_pkg::OFS_CTRL_HI, cfg);
          sfr_rd((p < 2) ? apcsd_pkg::OFS_CTRL_LO : apcsd_pkg::OFS_CTRL_HI, cfg, "ctrl");
          sfr_rd(apcsd_pkg::OFS_BASE_HI[p], base[15:8], "base high");
          sfr_wr(apcsd_pkg::OFS_POLARITY, (8'(pol) << (4 + p)) | 8'h0c);
          xacc(base ^ hit_x[l], 1'b1, 1'b0, 1'b0, p, f[0], pol);
          xacc(base ^ hit_x[l], 1'b0, 1'b1, 1'b0, p, f[1], pol);
          xacc(base ^ miss_x[l], 1'b1, 1'b1, 1'b0, p, 1'b0, pol);
          xacc(base ^ hit_x[l], 1'b1, 1'b0, 1'b1, p, 1'b0, pol);
        end
      end
    end
    // Second reset in mid-run clears everything that was configured
    do_reset();
    sfr_rd(apcsd_pkg::OFS_POLARITY, 8'h00, "polarity reset");
    sfr_rd(apcsd_pkg::OFS_CTRL_LO, 8'h00, "ctrl low reset");
    sfr_rd(apcsd_pkg::OFS_CTRL_HI, 8'h00, "ctrl high reset");
    for (int p = 0; p < 4; p++) begin
      sfr_rd(apcsd_pkg::OFS_BASE_LO[p], 8'h00, "base low reset");
      sfr_rd(apcsd_pkg::OFS_BASE_HI[p], 8'h00, "base high reset");
    end
    // Reserved polarity bits store but do nothing; low bits read zero
    sfr_wr(apcsd_pkg::OFS_POLARITY, 8'hff);
    sfr_rd(apcsd_pkg::OFS_POLARITY, 8'hfc, "polarity readback");
    chk8("port pins after polarity", 8'h0f, {4'h0, aux_pin_out});
    // Port mode: data bits drive the pins, ones released to the pull-up
    ext_low = 4'h1;
    sfr_wr(apcsd_pkg::OFS_PORT_DATA, 8'hf5);
    repeat (4) @(negedge clk_sys_in);
    chk8("port pins", 8'h05, {4'h0, aux_pin_out});
    chk8("port enables", 8'h0a, {4'h0, aux_pin_oe_out});
    sfr_rd(apcsd_pkg::OFS_PORT_DATA, 8'h04, "port input");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
